// ### shared/smf_pkg.sv
package smf_pkg;
   // command pin decode
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] SEL_MR4 = 3'h4;
   localparam logic [2:0] SEL_MR5 = 3'h5;
   localparam int MR_W = 22;
   // select field position
   localparam int SEL_LSB = 18;
   // fifth register fields
   localparam int F5_RD_INV = 12;
   localparam int F5_WR_INV = 11;
   localparam int F5_MASK = 10;
   localparam int F5_PERSIST = 9;
   localparam int F5_PARK_LSB = 6;
   localparam int F5_TERM_BUF = 5;
   localparam int F5_PAR_ERR = 4;
   localparam int F5_CRC_ERR = 3;
   localparam int F5_PLAT_LSB = 0;
   // fourth register fields (coined layout)
   localparam int F4_HARD_REP = 13;
   localparam int F4_WPRE = 12;
   localparam int F4_RPRE = 11;
   localparam int F4_RPRE_TRAIN = 10;
   localparam int F4_CAL_LSB = 6;
   localparam int F4_SOFT_REP = 5;
   localparam int F4_TCR_EN = 3;
   localparam int F4_TCR_RANGE = 2;
   localparam int F4_MAXPS = 1;
   // writable mask for fifth register: bits 12:5 and 2:0
   localparam logic [21:0] MR5_WMASK = 22'h001FE7;
   localparam logic [21:0] MR4_WMASK = 22'h003DEE;
   localparam logic [21:0] MR_RST = 22'h000000;
   // readout page 2 location zero bits
   localparam int RO_HARD_AVAIL = 7;
   localparam int RO_SOFT_AVAIL = 6;
   localparam int BANKS = 16;
   localparam int ROW_W = 17;
   // refresh skipping: 1 of N commands skipped when cool
   localparam logic [1:0] TCR_SKIP_NORM = 2'h1;
   localparam logic [1:0] TCR_SKIP_EXT = 2'h3;
endpackage : smf_pkg

// ### tb/sdram_mode_five_feature_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; \
$display("wrong value %s exp %0h got %0h", n, e, a); end end
module sdram_mode_five_feature_ctrl_tb;
   import smf_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic maxps_exit = 1'b0, pwr_down = 1'b0, refresh_cmd = 1'b0, cool_temp = 1'b0;
   logic crc_err_evt = 1'b0, rep_req = 1'b0;
   logic [3:0] rep_bank = 4'h0;
   logic [16:0] rep_row = 17'h00000;
   logic cs_n, row_strobe_n, col_strobe_n, write_en_n, par_in;
   logic [21:0] addr, mode_register_five, mode_register_four;
   logic [7:0] readout_location_zero;
   logic read_preamble_two, write_preamble_two, preamble_train_drive, refresh_do;
   logic [8:0] parked_termination_ohm;
   logic term_buf_on, parity_check_on, in_max_power_save;
   logic [2:0] parity_latency_clk;
   logic [15:0] hard_used, soft_used;
   int err_count = 0;
   int tests_run = 0;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   smf_ctrl_model u_smf_ctrl_model (.clk, .cs_n, .row_strobe_n, .col_strobe_n, .write_en_n,
      .addr, .par_in);
   smf_mode_ctrl u_smf_mode_ctrl (
      .clk, .rst, .cs_n, .row_strobe_n, .col_strobe_n, .write_en_n, .addr, .par_in,
      .maxps_exit, .pwr_down, .refresh_cmd, .cool_temp, .crc_err_evt, .rep_req,
      .rep_bank, .rep_row, .mode_register_five, .mode_register_four,
      .readout_location_zero, .cmd_vld(), .cmd_code(), .cmd_addr(), .read_preamble_two,
      .write_preamble_two, .preamble_train_drive, .refresh_do, .parked_termination_ohm,
      .term_buf_on, .parity_latency_clk, .parity_check_on, .in_max_power_save,
      .hard_used, .soft_used);
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   // write, then one more edge after the one that lands it
   task automatic wr(input logic [2:0] sel, input logic [21:0] v, input logic bad);
      u_smf_ctrl_model.mode_register_set_command(sel, v, bad);
      @(posedge clk);
      #1;
   endtask : wr
   // repair request with the given fourth-register mode
   task automatic rep(input logic [3:0] b, input logic [21:0] m4);
      wr(SEL_MR4, m4, 1'b0);
      @(posedge clk);
      rep_bank <= b;
      rep_row <= 17'h1ABCD;
      rep_req <= 1'b1;
      @(posedge clk);
      rep_req <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : rep
   task automatic t_fields;
      int ohm[8] = '{0, 60, 120, 40, 240, 48, 80, 34};
      logic [21:0] v;
      `CHK("avail hard", 1'b1, readout_location_zero[7]);
      `CHK("avail soft", 1'b1, readout_location_zero[6]);
      `CHK("status rst", 22'h0, mode_register_five);
      @(posedge clk);
      pwr_down <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         v = (22'(c) << 6) | (c[0] ? 22'h001420 : 22'h000800);
         wr(SEL_MR5, v, 1'b0);
         `CHK("mr5", v, mode_register_five);
         `CHK("park", 9'(ohm[c]), parked_termination_ohm);
         `CHK("odt buf", ~v[5], term_buf_on);
      end
      pwr_down <= 1'b0;
      wr(3'h6, 22'h000040, 1'b0);
      `CHK("other sel", 22'h0015E0, mode_register_five);
   endtask : t_fields
   task automatic t_parity;
      int lat[4] = '{0, 4, 5, 6};
      for (int c = 0; c < 4; c++) begin
         wr(SEL_MR5, 22'(c), 1'b0);
         `CHK("par lat", 3'(lat[c]), parity_latency_clk);
      end
      wr(SEL_MR5, 22'h000001, 1'b0);
      wr(SEL_MR5, 22'h000C01, 1'b1);
      repeat (4) @(posedge clk);
      #1 `CHK("par err", 22'h000011, mode_register_five);
      `CHK("chk off", 1'b0, parity_check_on);
      wr(SEL_MR5, 22'h000201, 1'b0);
      `CHK("par clr", 22'h000201, mode_register_five);
      wr(SEL_MR5, 22'h000A01, 1'b1);
      `CHK("persist", 22'h000211, mode_register_five);
      `CHK("chk on", 1'b1, parity_check_on);
      wr(SEL_MR5, 22'h0, 1'b0);
      @(posedge clk);
      crc_err_evt <= 1'b1;
      @(posedge clk);
      crc_err_evt <= 1'b0;
      repeat (3) @(posedge clk);
      #1 `CHK("crc err", 1'b1, mode_register_five[F5_CRC_ERR]);
      wr(SEL_MR5, 22'h0, 1'b0);
      `CHK("crc clr", 1'b0, mode_register_five[F5_CRC_ERR]);
   endtask : t_parity
   task automatic t_mr4;
      int ex[3] = '{2, 3, 4};
      int n;
      logic [21:0] m[3] = '{22'h000008, 22'h00000C, 22'h00000C};
      for (int i = 0; i < 2; i++) begin
         wr(SEL_MR4, i ? 22'h0 : 22'h001C00, 1'b0);
         `CHK("preamble", {3{i == 0}},
            {write_preamble_two, read_preamble_two, preamble_train_drive});
      end
      wr(SEL_MR4, 22'h000040, 1'b0);
      fork
         u_smf_ctrl_model.mode_register_set_command(SEL_MR5, 22'h000800, 1'b0);
         begin
            repeat (3) @(posedge clk);
            #1 `CHK("cal early", 22'h0, mode_register_five);
         end
      join
      @(posedge clk);
      #1 `CHK("cal late", 22'h000800, mode_register_five);
      wr(SEL_MR4, 22'h0, 1'b0);
      for (int i = 0; i < 3; i++) begin
         wr(SEL_MR4, m[i], 1'b0);
         @(posedge clk);
         cool_temp <= (i < 2);
         n = 0;
         repeat (4) begin
            @(posedge clk);
            refresh_cmd <= 1'b1;
            #1 if (refresh_do === 1'b1) n++;
            @(posedge clk);
            refresh_cmd <= 1'b0;
         end
         `CHK("refreshes", ex[i], n);
      end
   endtask : t_mr4
   task automatic t_repair;
      rep(4'h3, 22'h002000);
      `CHK("hard", 16'h0008, hard_used);
      rep(4'h5, 22'h000020);
      `CHK("soft", 16'h0020, soft_used);
      @(posedge clk);
      pwr_down <= 1'b1;
      @(posedge clk);
      pwr_down <= 1'b0;
      @(posedge clk);
      #1 `CHK("soft pd", 16'h0, soft_used);
      rep(4'h5, 22'h000020);
      wr(SEL_MR4, 22'h000002, 1'b0);
      `CHK("maxps", 1'b1, in_max_power_save);
      `CHK("mr4 view", 22'h000002, mode_register_four);
      wr(SEL_MR5, 22'h000400, 1'b0);
      `CHK("ignored", 22'h000800, mode_register_five);
      @(posedge clk);
      maxps_exit <= 1'b1;
      @(posedge clk);
      maxps_exit <= 1'b0;
      @(posedge clk);
      #1 `CHK("exit", 1'b0, in_max_power_save);
      wr(SEL_MR4, 22'h0, 1'b0);
      wr(SEL_MR4, 22'h000002, 1'b0);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 `CHK("rst exit", 1'b0, in_max_power_save);
      `CHK("hard kept", 16'h0008, hard_used);
      `CHK("soft lost", 16'h0, soft_used);
   endtask : t_repair
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_fields();
      t_parity();
      t_mr4();
      t_repair();
      final_report();
   end
   // watchdog
   initial begin
      #(25 * 5000);
      err_count++;
      final_report();
   end
endmodule : sdram_mode_five_feature_ctrl_tb

// ### tb/smf_ctrl_model.sv
`timescale 1ns/1ps
// controller model: issues mode-register writes on the command pins
module smf_ctrl_model
   import smf_pkg::*;
(
   // clock
   input wire logic clk,
   // command pins
   output logic cs_n,
   output logic row_strobe_n,
   output logic col_strobe_n,
   output logic write_en_n,
   output logic [21:0] addr,
   output logic par_in
);
   // latency in clocks that the model programmed last
   int cal = 0;
   // no writes or gear-down issued, so latency limits hold
   // idle pins at time zero
   initial begin
      cs_n = 1'b1;
      row_strobe_n = 1'b1;
      col_strobe_n = 1'b1;
      write_en_n = 1'b1;
      addr = 22'h3FFFFF;
      par_in = 1'b0;
   end
   // one write; select low, command after the latency, then release
   task automatic mode_register_set_command(input logic [2:0] sel, input logic [21:0] v, input logic bad);
      logic [21:0] a;
      a = v;
      a[21] = 1'b0;
      a[17] = 1'b0;
      if (sel == SEL_MR5) a[13] = 1'b0;
      a[20:18] = sel;
      @(posedge clk);
      cs_n <= 1'b0;
      if (cal > 0) begin
         @(posedge clk);
         cs_n <= 1'b1;
         repeat (cal - 1) @(posedge clk);
      end
      row_strobe_n <= 1'b0;
      col_strobe_n <= 1'b0;
      write_en_n <= 1'b0;
      addr <= a;
      par_in <= (^a) ^ bad;
      @(posedge clk);
      cs_n <= 1'b1;
      row_strobe_n <= 1'b1;
      col_strobe_n <= 1'b1;
      write_en_n <= 1'b1;
      addr <= ~a;
      par_in <= ~((^a) ^ bad);
      if (sel == SEL_MR4) begin
         case (a[8:6])
            3'h1: cal = 3;
            3'h2: cal = 4;
            3'h3: cal = 5;
            3'h4: cal = 6;
            3'h5: cal = 8;
            default: cal = 0;
         endcase
      end
   endtask : mode_register_set_command
endmodule : smf_ctrl_model

// ### verilog/smf_cmd_delay.sv
`timescale 1ns/1ps
// delays the select mark by a programmable number of clocks; command and address pass through live
module smf_cmd_delay
   import smf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // input command
   input wire logic in_vld,
   input wire logic [2:0] in_cmd,
   input wire logic [21:0] in_addr,
   input wire logic [3:0] dly,
   // delayed command
   output logic out_vld,
   output logic [2:0] out_cmd,
   output logic [21:0] out_addr
);
   logic [7:0] vld_r;

   // shift line of select-low marks only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vld_r <= '0;
      end else begin
         vld_r <= {vld_r[6:0], in_vld};
      end
   end

   // command and address are taken live on the delayed select edge
   always_comb begin
      out_cmd = in_cmd;
      out_addr = in_addr;
      if (dly == 4'h0) begin
         out_vld = in_vld;
      end else begin
         out_vld = vld_r[3'(dly - 4'h1)];
      end
   end
endmodule : smf_cmd_delay

// ### verilog/smf_mode_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - readout bit 7 shows hard repair availability
// - hard repair one row per bank, permanent
// - readout bit 6 shows soft repair availability
// - soft repair one row per bank, lost on reset
// - read preamble one or two clocks
// - preamble training drives strobe pattern
// - refresh skipping with normal or extended range
// - command captured latency clocks after select
// - power saving drops commands and refreshes; exit, reset, repair, power-down, crc error and bad command parity still act
// - fifth register written when bank bits 101
// - bits 12,11,10 enable inversion and mask
// - bit 9 keeps parity checking while error
// - bits 8:6 select parked termination
// - bit 5 disables termination buffer in power-down
// - bit 4 parity error, bit 3 CRC error
// - bits 2:0 select parity latency
// - error bits stay set until register write
// - parity checking stops while error set unless persistent
module smf_mode_ctrl
   import smf_pkg::*;
#(
   parameter logic HARD_AVAIL = 1'b1,
   parameter logic SOFT_AVAIL = 1'b1
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command pins, already on clk
   input wire logic cs_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_en_n,
   input wire logic [21:0] addr,
   input wire logic par_in,
   // other device commands and events
   input wire logic maxps_exit,
   input wire logic pwr_down,
   input wire logic refresh_cmd,
   input wire logic cool_temp,
   input wire logic crc_err_evt,
   input wire logic rep_req,
   input wire logic [3:0] rep_bank,
   input wire logic [16:0] rep_row,
   // decoded state
   output logic [21:0] mode_register_five,
   output logic [21:0] mode_register_four,
   output logic [7:0] readout_location_zero,
   output logic cmd_vld,
   output logic [2:0] cmd_code,
   output logic [21:0] cmd_addr,
   output logic read_preamble_two,
   output logic write_preamble_two,
   output logic preamble_train_drive,
   output logic refresh_do,
   output logic [8:0] parked_termination_ohm,
   output logic term_buf_on,
   output logic [2:0] parity_latency_clk,
   output logic parity_check_on,
   output logic in_max_power_save,
   output logic [15:0] hard_used,
   output logic [15:0] soft_used
);
   logic [21:0] mr5_r;
   logic [21:0] mr4_r;
   logic par_err_r;
   logic crc_err_r;
   logic maxps_r;
   logic [1:0] skip_cnt_r;
   logic [3:0] cal_dly;
   logic raw_vld;
   logic dly_vld;
   logic [2:0] dly_cmd;
   logic [21:0] dly_addr;
   logic mrs_take;
   logic mr5_wr;
   logic mr4_wr;
   logic par_bad;
   logic [2:0] plat;

   // command latency: field code to clocks
   always_comb begin
      unique case (mr4_r[F4_CAL_LSB +: 3])
         3'h1: cal_dly = 4'h3;
         3'h2: cal_dly = 4'h4;
         3'h3: cal_dly = 4'h5;
         3'h4: cal_dly = 4'h6;
         3'h5: cal_dly = 4'h8;
         default: cal_dly = 4'h0;
      endcase
   end

   // select sampled low starts a command
   assign raw_vld = !cs_n;

   // command and address taken latency clocks after select
   smf_cmd_delay u_dly (
      .clk(clk),
      .rst(rst),
      .in_vld(raw_vld),
      .in_cmd({row_strobe_n, col_strobe_n, write_en_n}),
      .in_addr(addr),
      .dly(cal_dly),
      .out_vld(dly_vld),
      .out_cmd(dly_cmd),
      .out_addr(dly_addr)
   );

   // even parity over command and address
   assign par_bad = plat != 3'h0 && (^{dly_cmd, dly_addr, par_in});
   assign parity_check_on = plat != 3'h0 && (!par_err_r || mr5_r[F5_PERSIST]);

   // accepted command: power save ignores all, bad parity drops
   assign mrs_take = dly_vld && !maxps_r && dly_cmd == CMD_MRS
      && !(parity_check_on && par_bad);
   assign mr5_wr = mrs_take && dly_addr[SEL_LSB +: 3] == SEL_MR5;
   assign mr4_wr = mrs_take && dly_addr[SEL_LSB +: 3] == SEL_MR4;

   // command outputs toward the array, gated in power save
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_vld <= 1'b0;
         cmd_code <= 3'h7;
         cmd_addr <= 22'h000000;
      end else begin
         cmd_vld <= dly_vld && !maxps_r && !(parity_check_on && par_bad);
         cmd_code <= dly_cmd;
         cmd_addr <= dly_addr;
      end
   end

   // fifth register: writable fields only, reserved and select read zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mr5_r <= MR_RST;
      end else if (mr5_wr) begin
         mr5_r <= dly_addr & MR5_WMASK;
      end
   end

   // fourth register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mr4_r <= MR_RST;
      end else if (mr4_wr) begin
         mr4_r <= dly_addr & MR4_WMASK;
      end
   end

   // parity error flag: set wins over the clearing write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         par_err_r <= 1'b0;
      end else if (dly_vld && parity_check_on && par_bad) begin
         par_err_r <= 1'b1;
      end else if (mr5_wr && !dly_addr[F5_PAR_ERR]) begin
         par_err_r <= 1'b0;
      end
   end

   // crc error flag: set wins over the clearing write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         crc_err_r <= 1'b0;
      end else if (crc_err_evt) begin
         crc_err_r <= 1'b1;
      end else if (mr5_wr && !dly_addr[F5_CRC_ERR]) begin
         crc_err_r <= 1'b0;
      end
   end

   // max power save: entered by register bit, left by exit command or reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         maxps_r <= 1'b0;
      end else if (maxps_r && maxps_exit) begin
         maxps_r <= 1'b0;
      end else if (mr4_wr && dly_addr[F4_MAXPS]) begin
         maxps_r <= 1'b1;
      end
   end

   // refresh skipping when cool, ratio by range bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         skip_cnt_r <= 2'h0;
      end else if (refresh_cmd) begin
         skip_cnt_r <= skip_cnt_r + 2'h1;
      end
   end
   always_comb begin
      refresh_do = refresh_cmd && !maxps_r;
      if (mr4_r[F4_TCR_EN] && cool_temp) begin
         if (mr4_r[F4_TCR_RANGE]) begin
            refresh_do = refresh_do && (skip_cnt_r & TCR_SKIP_EXT) != 2'h0;
         end else begin
            refresh_do = refresh_do && (skip_cnt_r & TCR_SKIP_NORM) != 2'h0;
         end
      end
   end

   // parked termination code to ohms
   always_comb begin
      unique case (mr5_r[F5_PARK_LSB +: 3])
         3'h1: parked_termination_ohm = 9'h03C;
         3'h2: parked_termination_ohm = 9'h078;
         3'h3: parked_termination_ohm = 9'h028;
         3'h4: parked_termination_ohm = 9'h0F0;
         3'h5: parked_termination_ohm = 9'h030;
         3'h6: parked_termination_ohm = 9'h050;
         3'h7: parked_termination_ohm = 9'h022;
         default: parked_termination_ohm = 9'h000;
      endcase
   end

   // parity latency code to clocks, reserved codes disable
   always_comb begin
      unique case (mr5_r[F5_PLAT_LSB +: 3])
         3'h1: plat = 3'h4;
         3'h2: plat = 3'h5;
         3'h3: plat = 3'h6;
         default: plat = 3'h0;
      endcase
   end
   assign parity_latency_clk = plat;

   // termination buffer off only in power-down with bit 5 set
   assign term_buf_on = !(pwr_down && mr5_r[F5_TERM_BUF]);

   // readable views with live status bits
   always_comb begin
      mode_register_five = mr5_r;
      mode_register_five[F5_PAR_ERR] = par_err_r;
      mode_register_five[F5_CRC_ERR] = crc_err_r;
   end
   assign mode_register_four = {mr4_r[21:2], maxps_r, mr4_r[0]};
   assign readout_location_zero = {HARD_AVAIL, SOFT_AVAIL, 6'h00};
   assign read_preamble_two = mr4_r[F4_RPRE];
   assign write_preamble_two = mr4_r[F4_WPRE];
   assign preamble_train_drive = mr4_r[F4_RPRE_TRAIN];
   assign in_max_power_save = maxps_r;

   // row repair, only in the matching repair mode
   smf_repair u_rep (
      .clk(clk),
      .rst(rst),
      .pwr_down(pwr_down),
      .rep_vld(rep_req && (mr4_r[F4_HARD_REP] ? HARD_AVAIL : mr4_r[F4_SOFT_REP] && SOFT_AVAIL)),
      .rep_hard(mr4_r[F4_HARD_REP]),
      .rep_bank(rep_bank),
      .rep_row(rep_row),
      .hard_used(hard_used),
      .soft_used(soft_used)
   );

   chk_err_sticky: assert property (@(posedge clk) disable iff (rst)
      $rose(par_err_r) |=> par_err_r || $past(mr5_wr))
      else $error("parity error flag dropped without write");
   chk_crc_set: assert property (@(posedge clk) disable iff (rst)
      crc_err_evt |=> mode_register_five[F5_CRC_ERR])
      else $error("crc event not flagged");
   chk_mr5_fields: assert property (@(posedge clk) disable iff (rst)
      mr5_wr |=> mr5_r[12:5] == $past(dly_addr[12:5]))
      else $error("fifth register fields not stored");
   chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      mode_register_five[21:13] == 9'h000)
      else $error("reserved bits nonzero");
   chk_maxps_ignore: assert property (@(posedge clk) disable iff (rst)
      maxps_r && !maxps_exit |=> !cmd_vld && maxps_r)
      else $error("command taken in power save");
   chk_parity_stop: assert property (@(posedge clk) disable iff (rst)
      par_err_r && !mr5_r[F5_PERSIST] |-> !parity_check_on)
      else $error("parity checked while error set");
   chk_park_off: assert property (@(posedge clk) disable iff (rst)
      mr5_r[8:6] == 3'h0 |-> parked_termination_ohm == 9'h000)
      else $error("parked termination on when disabled");
   chk_cal_delay: assert property (@(posedge clk) disable iff (rst)
      raw_vld && cal_dly == 4'h3 |-> ##3 dly_vld)
      else $error("latency path broken");
   chk_hard_keep: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> (hard_used & $past(hard_used)) == $past(hard_used))
      else $error("hard repair lost");
   cov_mr5_write: cover property (@(posedge clk) mr5_wr);
   cov_par_err: cover property (@(posedge clk) $rose(par_err_r));
   cov_maxps: cover property (@(posedge clk) $fell(maxps_r));
endmodule : smf_mode_ctrl

// ### verilog/smf_repair.sv
`timescale 1ns/1ps
// per-bank row repair store: hard entries permanent, soft entries volatile
module smf_repair
   import smf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic pwr_down,
   // repair request
   input wire logic rep_vld,
   input wire logic rep_hard,
   input wire logic [3:0] rep_bank,
   input wire logic [16:0] rep_row,
   // status
   output logic [15:0] hard_used,
   output logic [15:0] soft_used
);
   logic [16:0] hard_row_r [0:15];
   logic [16:0] soft_row_r [0:15];
   // power-on value only; no reset term, repair is permanent
   logic [15:0] hard_used_r = 16'h0000;
   logic [15:0] soft_used_r;

   // hard repair: no reset term, never cleared once used
   always_ff @(posedge clk) begin
      if (rep_vld && rep_hard && !hard_used_r[rep_bank]) begin
         hard_row_r[rep_bank] <= rep_row;
      end
   end

   // one row per bank, irreversible
   always_ff @(posedge clk) begin
      if (rep_vld && rep_hard) begin
         hard_used_r[rep_bank] <= 1'b1;
      end
   end

   // soft repair: rewrite replaces, reset or power-down discards
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         soft_used_r <= 16'h0000;
      end else if (pwr_down) begin
         soft_used_r <= 16'h0000;
      end else if (rep_vld && !rep_hard) begin
         soft_used_r[rep_bank] <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rep_vld && !rep_hard) begin
         soft_row_r[rep_bank] <= rep_row;
      end
   end

   assign hard_used = hard_used_r;
   assign soft_used = soft_used_r;
endmodule : smf_repair
